/* File: tb_top.sv */
// self-checking testbench for the 36-bit arithmetic core
`timescale 1ns/1ps
`include "w36_defs.vh"
module tb_top;
  logic        clk, resetn, start, done, ovf, cry0, cry1;
  logic        res_neg, res_zero, res_norm;
  logic [3:0]  op;
  logic [35:0] op_a, op_b, op_lo, res_hi, res_lo;
  int          fail_count, samples_checked;

  w36_seq_model u_seq (.clk, .start, .op, .op_a, .op_b, .op_lo);
  w36_arith dut (.clk, .resetn, .start, .op, .op_a, .op_b, .op_lo, .res_hi,
    .res_lo, .done, .ovf, .cry0, .cry1, .res_neg, .res_zero, .res_norm);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cmp(input logic [35:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // answer lands at the taking edge and is checked 1ns later
  task automatic run(input logic [3:0] o, input logic [35:0] a, b, lo);
    u_seq.issue(o, a, b, lo);
    #1;
    cmp(done, 1'b1);
  endtask

  task automatic t_neg;
    logic [35:0] v [4] = '{36'h5, 36'h0, `W36_MOST_NEG, 36'h444C80000};
    foreach (v[i]) begin
      run(`W36_OP_NEG, v[i], 0, 0);
      cmp(res_hi, ~v[i] + 36'h1);
      cmp(ovf, v[i] == `W36_MOST_NEG);
      @(posedge clk);
    end
    run(`W36_OP_NEG, 36'h0, 0, 0);
    cmp(cry0, 1'b1);
    cmp(cry1, 1'b1);
    @(posedge clk);
    run(`W36_OP_FNEG, 36'h444C80000, 0, 0);
    cmp(res_hi, 36'hBBB380000);
    cmp(res_hi[34:27], 8'h77);
    cmp(res_norm, 1'b1);
    @(posedge clk);
    $display("test negate finished");
  endtask

  task automatic t_add;
    logic [35:0] a [4] = '{36'h1, 36'h7FFFFFFFF, `W36_MOST_NEG, 36'hFFFFFFFFF};
    logic [35:0] b [4] = '{36'h2, 36'h1, 36'hFFFFFFFFF, 36'h1};
    logic [35:0] s;
    logic [36:0] w;
    foreach (a[i]) begin
      s = a[i] + b[i];
      w = a[i] + b[i];
      run(`W36_OP_ADD, a[i], b[i], 0);
      cmp(res_hi, s);
      cmp(ovf, a[i][35] == b[i][35] && s[35] != a[i][35]);
      cmp(res_neg, s[35]);
      cmp(res_zero, s == 0);
      cmp(cry1, w[36]);
      cmp(cry0, s[35] ^ a[i][35] ^ b[i][35]);
      @(posedge clk);
    end
    run(`W36_OP_SUB, 36'h3, 36'h5, 0);
    cmp(res_hi, 36'hFFFFFFFFE);
    @(posedge clk);
    $display("test add finished");
  endtask

  task automatic t_muldiv;
    logic signed [71:0] p;
    p = $signed(36'h3) * $signed(36'hFFFFFFFFE);
    run(`W36_OP_MUL, 36'h3, 36'hFFFFFFFFE, 0);
    cmp(res_hi, p[70:35]);
    cmp(res_lo, {p[70], p[34:0]});
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      run(`W36_OP_DIV, 0, 36'h7, {k[0], 35'h64});
      cmp(res_hi, 36'hE);
      cmp(res_lo, 36'h2);
      @(posedge clk);
    end
    run(`W36_OP_DIV, 36'hFFFFFFFFF, 36'h7, 36'hFFFFFFF9C);
    cmp(res_hi, 36'hFFFFFFFF2);
    cmp(res_lo, 36'hFFFFFFFFE);
    @(posedge clk);
    run(`W36_OP_DIV, 36'h5, 0, 36'h9);
    cmp(ovf, 1'b1);
    cmp(res_hi, 36'h5);
    cmp(res_lo, 36'h9);
    @(posedge clk);
    run(`W36_OP_MUL, `W36_MOST_NEG, `W36_MOST_NEG, 0);
    cmp(ovf, 1'b1);
    @(posedge clk);
    $display("test multiply divide finished");
  endtask

  task automatic t_half;
    logic [35:0] v [3] = '{36'hFFFFFFFFF, 36'h00017FFFF, 36'h0};
    foreach (v[i]) begin
      run(`W36_OP_INCH, v[i], 0, 0);
      cmp(res_hi, {v[i][35:18] + 18'h1, v[i][17:0] + 18'h1});
      @(posedge clk);
      run(`W36_OP_DECH, v[i], 0, 0);
      cmp(res_hi, {v[i][35:18] - 18'h1, v[i][17:0] - 18'h1});
      @(posedge clk);
    end
    $display("test half step finished");
  endtask

  task automatic t_fsc;
    run(`W36_OP_FSC, 36'h444C80000, 36'h2, 0);
    cmp(res_hi, 36'h454C80000);
    @(posedge clk);
    run(`W36_OP_FSC, 36'hBBB380000, 36'h3FFFD, 0);
    cmp(res_hi, 36'hBD3380000);
    cmp(res_hi[34:27], 8'h7A);
    @(posedge clk);
    run(`W36_OP_FSC, 36'h444C80000, 36'hC8, 0);
    cmp(ovf, 1'b1);
    @(posedge clk);
    $display("test scale finished");
  endtask

  task automatic t_misc;
    run(`W36_OP_FCHK, 36'h444C80000, 0, 0);
    cmp(res_hi, 36'h444C80000);
    cmp(res_norm, 1'b1);
    @(posedge clk);
    run(`W36_OP_FCHK, 36'h440000000, 0, 0);
    cmp(res_norm, 1'b0);
    @(posedge clk);
    run(4'hF, 36'h123456789, 36'h1, 0);
    cmp(res_hi, 36'h0);
    cmp(res_zero, 1'b1);
    @(posedge clk);
    $display("test float check finished");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    fail_count++;
    test_done;
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    cmp(res_zero, 1'b1);
    resetn <= 1'b1;
    @(posedge clk);
    t_neg;
    t_add;
    t_muldiv;
    t_half;
    t_fsc;
    t_misc;
    test_done;
  end
endmodule // tb_top

/* File: w36_arith.v */
// 36-bit fixed and floating number format arithmetic core
`timescale 1ns/1ps
`include "w36_defs.vh"

module w36_arith #(
  parameter OPW = 4
) (
  // clock and reset
  input  wire            clk,
  input  wire            resetn,
  // request
  input  wire            start,
  input  wire [OPW-1:0]  op,
  input  wire [35:0]     op_a,
  input  wire [35:0]     op_b,
  input  wire [35:0]     op_lo,
  // result words
  output reg  [35:0]     res_hi,
  output reg  [35:0]     res_lo,
  // status
  output reg             done,
  output reg             ovf,
  output reg             cry0,
  output reg             cry1,
  output reg             res_neg,
  output reg             res_zero,
  output reg             res_norm
);

  // ********************
  // operation decode
  // ********************
  // port bit 35 is the leftmost (sign) bit and port bit 0 the rightmost
  wire        is_sub;
  wire        is_neg;

  assign is_sub  = (op == `W36_OP_SUB);
  assign is_neg  = (op == `W36_OP_NEG) || (op == `W36_OP_FNEG);

  // ********************
  // shared adder
  // ********************
  wire [35:0] add_x;
  wire [35:0] add_y;
  wire        add_cin;
  wire [35:0] low_sum;
  wire [1:0]  top_sum;
  wire        add_c0;
  wire        add_c1;
  wire [35:0] add_sum;

  // negation rides the adder as 0 + ~a + 1 so fixed negate shares its flags
  assign add_x   = is_neg ? `W36_ZERO : op_a;
  assign add_y   = is_sub ? ~op_b : (is_neg ? ~op_a : op_b);
  assign add_cin = is_sub | is_neg;

  // magnitude stages first, sign stage treated like any other bit
  assign low_sum = {1'b0, add_x[34:0]} + {1'b0, add_y[34:0]}
                 + {35'h0, add_cin};
  assign add_c0  = low_sum[35];
  assign top_sum = {1'b0, add_x[35]} + {1'b0, add_y[35]}
                 + {1'b0, add_c0};
  assign add_c1  = top_sum[1];
  assign add_sum = {top_sum[0], low_sum[34:0]};

  // ********************
  // multiply
  // ********************
  wire signed [71:0] mul_x;
  wire signed [71:0] mul_y;
  wire signed [71:0] mul_p;
  wire        [35:0] mul_hi;
  wire        [35:0] mul_lo;
  wire               mul_ovf;

  // both factors are sign-extended to the full product width
  assign mul_x   = $signed({{36{op_a[35]}}, op_a});
  assign mul_y   = $signed({{36{op_b[35]}}, op_b});
  assign mul_p   = mul_x * mul_y;
  // product sign sits in p[70]; bits 1-35 of both words carry 70 bits
  assign mul_hi  = mul_p[70:35];
  assign mul_lo  = {mul_p[70], mul_p[34:0]};
  // only most-negative squared reaches 2^70
  assign mul_ovf = mul_p[71] ^ mul_p[70];

  // ********************
  // divide
  // ********************
  wire signed [71:0] div_n;
  wire signed [71:0] div_d;
  wire signed [71:0] div_dsafe;
  wire signed [71:0] div_q;
  wire signed [71:0] div_r;
  wire               div_zero;
  wire               div_fit;
  wire               div_ovf;

  // low word bit 0 dropped whatever it holds
  assign div_n    = $signed({op_a[35], op_a, op_lo[34:0]});
  assign div_d    = $signed({{36{op_b[35]}}, op_b});
  assign div_zero = (op_b == `W36_ZERO);
  // a zero divisor is swapped for one so the divider never sees it;
  // both operands stay signed so the quotient truncates toward zero
  assign div_dsafe = div_zero ? 72'sh1 : div_d;
  assign div_q    = div_n / div_dsafe;
  assign div_r    = div_n % div_dsafe;
  assign div_fit  = (&div_q[71:35]) | ~(|div_q[71:35]);
  assign div_ovf  = div_zero | ~div_fit;

  // ********************
  // half-word step
  // ********************
  wire [35:0] half_inc;
  wire [35:0] half_dec;

  // right half steps as an address, left half as a count
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_half
      // each half wraps on its own, no carry into the other
      assign half_inc[`W36_HALF*g+17:`W36_HALF*g] =
        op_a[`W36_HALF*g+17:`W36_HALF*g] + `W36_HALF_ONE;
      assign half_dec[`W36_HALF*g+17:`W36_HALF*g] =
        op_a[`W36_HALF*g+17:`W36_HALF*g] - `W36_HALF_ONE;
    end
  endgenerate

  // ********************
  // exponent scale
  // ********************
  wire        fsc_neg;
  wire [35:0] fsc_pos;
  wire [7:0]  fsc_exp;
  wire [18:0] fsc_sum;
  wire        fsc_under;
  wire        fsc_over;
  wire        fsc_ovf;
  wire [35:0] fsc_npos;
  wire [35:0] fsc_word;

  assign fsc_neg  = op_a[`W36_SIGN];
  // work on the positive form, then negate back; the ones complement
  // exponent of a negative word then falls out of the whole-word negate
  assign fsc_pos  = fsc_neg ? (~op_a + `W36_ONE) : op_a;
  assign fsc_exp  = fsc_pos[`W36_EXP_HI:`W36_EXP_LO];
  // only the low 18 bits of op_b scale; higher bits are ignored
  assign fsc_sum  = {11'h0, fsc_exp}
                  + {op_b[17], op_b[17:0]};
  // excess-128 code must stay in 0..255
  assign fsc_under = fsc_sum[18];
  assign fsc_over  = ~fsc_sum[18] & (fsc_sum > `W36_EXP_MAX);
  assign fsc_ovf   = fsc_under | fsc_over;
  assign fsc_npos = {1'b0, fsc_sum[7:0], fsc_pos[`W36_FRAC_HI:0]};
  assign fsc_word = (op_a == `W36_ZERO) ? `W36_ZERO :
                    (fsc_neg ? (~fsc_npos + `W36_ONE)
                             : fsc_npos);

  // ********************
  // normalization test
  // ********************
  function norm_ok;
    input [35:0] w;
    reg   [35:0] m;
    begin
      m = w[35] ? (~w + `W36_ONE) : w;
      // most negative word has a zero fraction and is never normalized
      norm_ok = (w == `W36_ZERO) ||
                (~m[35] && m[`W36_FRAC_HI]);
    end
  endfunction

  // ********************
  // result select
  // ********************
  reg [35:0] next_hi;
  reg [35:0] next_lo;
  reg        next_ovf;
  reg        next_c0;
  reg        next_c1;
  reg        next_flt;

  always @* begin
    next_hi  = `W36_ZERO;
    next_lo  = `W36_ZERO;
    next_ovf = 1'b0;
    next_c0  = 1'b0;
    next_c1  = 1'b0;
    next_flt = 1'b0;
    case (op)
      `W36_OP_ADD, `W36_OP_SUB: begin
        next_hi  = add_sum;
        next_c0  = add_c0;
        next_c1  = add_c1;
        next_ovf = add_c0 ^ add_c1;
      end
      `W36_OP_NEG: begin
        // zero comes back as zero; most negative flags overflow
        next_hi  = add_sum;
        next_c0  = add_c0;
        next_c1  = add_c1;
        next_ovf = add_c0 ^ add_c1;
      end
      `W36_OP_FNEG: begin
        next_hi  = add_sum;
        next_flt = 1'b1;
      end
      `W36_OP_MUL: begin
        next_hi  = mul_hi;
        next_lo  = mul_lo;
        next_ovf = mul_ovf;
      end
      `W36_OP_DIV: begin
        // on overflow the dividend comes back untouched
        if (div_ovf) begin
          next_hi  = op_a;
          next_lo  = op_lo;
          next_ovf = 1'b1;
        end else begin
          next_hi  = div_q[35:0];
          next_lo  = div_r[35:0];
        end
      end
      `W36_OP_INCH: begin
        next_hi = half_inc;
      end
      `W36_OP_DECH: begin
        next_hi = half_dec;
      end
      `W36_OP_FSC: begin
        next_hi  = fsc_word;
        next_ovf = fsc_ovf & (op_a != `W36_ZERO);
        next_flt = 1'b1;
      end
      `W36_OP_FCHK: begin
        next_hi  = op_a;
        next_flt = 1'b1;
      end
      default: begin
        // unknown codes load zeros; only the zero flag is raised
        next_hi = `W36_ZERO;
      end
    endcase
  end

  // ********************
  // status flags
  // ********************
  wire        next_neg;
  wire        next_zero;
  wire        next_norm;

  assign next_neg  = next_hi[`W36_SIGN];
  assign next_zero = (next_hi == `W36_ZERO);
  // only float codes report normalization; fixed results read low
  assign next_norm = next_flt & norm_ok(next_hi);

  // ********************
  // output registers
  // ********************
  // done follows start on every edge, unknown codes included
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= start;
    end
  end

  // results hold between requests so the sequencer may read late
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_hi <= `W36_ZERO;
      res_lo <= `W36_ZERO;
    end else if (start) begin
      res_hi <= next_hi;
      res_lo <= next_lo;
    end
  end

  // overflow and carry flags belong to the last taken request only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovf  <= 1'b0;
      cry0 <= 1'b0;
      cry1 <= 1'b0;
    end else if (start) begin
      ovf  <= next_ovf;
      cry0 <= next_c0;
      cry1 <= next_c1;
    end
  end

  // zero reads true out of reset since the result words start cleared
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_neg  <= 1'b0;
      res_zero <= 1'b1;
      res_norm <= 1'b0;
    end else if (start) begin
      res_neg  <= next_neg;
      res_zero <= next_zero;
      res_norm <= next_norm;
    end
  end

endmodule // w36_arith

/* File: w36_arith_monitor.sv */
// assertion checker for the 36-bit arithmetic core
`timescale 1ns/1ps
`include "w36_defs.vh"
module w36_arith_monitor #(
  parameter OPW = 4
) (
  // request
  input wire logic           clk,
  input wire logic           resetn,
  input wire logic           start,
  input wire logic [OPW-1:0] op,
  input wire logic [35:0]    op_a,
  input wire logic [35:0]    op_b,
  input wire logic [35:0]    op_lo,
  // results
  input wire logic [35:0]    res_hi,
  input wire logic [35:0]    res_lo,
  input wire logic           done,
  input wire logic           ovf,
  input wire logic           cry0,
  input wire logic           cry1,
  input wire logic           res_neg,
  input wire logic           res_zero,
  input wire logic           res_norm
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire neg = start && (op == `W36_OP_NEG || op == `W36_OP_FNEG);
  wire add = start && op == `W36_OP_ADD;
  AST_NEG: assert property (neg |=>
    res_hi == ~$past(op_a) + 36'h1) else $error("negate wrong");
  AST_NEG_ZERO: assert property (neg && op_a == 0 |=>
    res_zero && !ovf) else $error("zero negate wrong");
  AST_MOST_NEG: assert property (
    start && op == `W36_OP_NEG && op_a == `W36_MOST_NEG |=>
    ovf && res_hi == `W36_MOST_NEG) else $error("most negative wrong");
  AST_ADD_RAW: assert property (add |=>
    res_hi == $past(op_a) + $past(op_b)) else $error("sum wrong");
  AST_ADD_SIGN: assert property (add |=>
    res_hi[35] == ($past(op_a[35]) ^ $past(op_b[35]) ^ cry0))
    else $error("sum sign wrong");
  AST_ADD_OVF: assert property (add |=> ovf ==
    ($past(op_a[35]) == $past(op_b[35]) && res_hi[35] != $past(op_a[35])))
    else $error("overflow wrong");
  AST_SIGN: assert property (done |->
    res_neg == res_hi[35] && res_zero == (res_hi == 0))
    else $error("status wrong");
  AST_HALF: assert property (start && op == `W36_OP_INCH |=>
    res_hi == {$past(op_a[35:18]) + 18'h1, $past(op_a[17:0]) + 18'h1})
    else $error("half step wrong");
  cover property (add ##1 ovf);
  cover property (start && op == `W36_OP_MUL);
  cover property (start && op == `W36_OP_FSC ##1 res_norm);
endmodule // w36_arith_monitor

bind w36_arith w36_arith_monitor #(.OPW(OPW)) u_mon (.clk, .resetn, .start,
  .op, .op_a, .op_b, .op_lo, .res_hi, .res_lo, .done, .ovf, .cry0, .cry1,
  .res_neg, .res_zero, .res_norm);

/* File: w36_defs.vh */
// constants for the 36-bit number format and arithmetic core
// Operation
// - bit 0 (leftmost) is the sign, 0 positive; other 35 bits magnitude
// - negate by complementing the whole word, sign included, then adding one
// - all-zero word is the only zero, positive; negating it gives zero
// - sign-bit-only word is the most negative value, one beyond largest
// - adder treats operands as 36-bit unsigned; sign stage carries normally
// - sum sign negative: carry with like signs, or none with unlike signs
// - flag overflow when the signed reading of the result is wrong
// - on overflow still deliver the raw sum bits unchanged
// - fixed multiply yields a double-length product in two words
// - double length: 70-bit magnitude in bits 1-35, low bit 0 copies sign
// - fixed divide ignores bit 0 of the low dividend word
// - float word: sign bit 0, exponent bits 1-8, fraction bits 9-35
// - positive float exponent is excess-128: -128..+127 maps to 0..255
// - negative float is whole-word twos complement; exponent 127 minus x
// - float zero is all zeros; float negate equals fixed negate
// - exponent scale reads factor as twos complement, fixes negatives
// - add or subtract one on both 18-bit halves at once
// - nonzero float normalized only if fraction magnitude in [1/2, 1)
`ifndef W36_DEFS_VH
`define W36_DEFS_VH

// ********************
// word layout
// ********************
`define W36_WORD      36
`define W36_HALF      18
`define W36_SIGN      35
`define W36_MAG_HI    34
`define W36_EXP_HI    34
`define W36_EXP_LO    27
`define W36_FRAC_HI   26
`define W36_MOST_NEG  36'h800000000
`define W36_ZERO      36'h000000000
`define W36_ONE       36'h000000001
`define W36_HALF_ONE  18'h00001

// ********************
// exponent scaling
// ********************
`define W36_EXP_MAX   19'h000FF

// ********************
// operation codes
// ********************
`define W36_OP_ADD    4'h0
`define W36_OP_SUB    4'h1
`define W36_OP_NEG    4'h2
`define W36_OP_MUL    4'h3
`define W36_OP_DIV    4'h4
`define W36_OP_INCH   4'h5
`define W36_OP_DECH   4'h6
`define W36_OP_FSC    4'h7
`define W36_OP_FNEG   4'h8
`define W36_OP_FCHK   4'h9

`endif

/* File: w36_seq_model.sv */
// operand fetch model that issues requests to the core
`timescale 1ns/1ps
module w36_seq_model (
  // clock
  input  wire logic   clk,
  // request
  output logic        start,
  output logic [3:0]  op,
  output logic [35:0] op_a,
  output logic [35:0] op_b,
  output logic [35:0] op_lo
);
  initial {start, op, op_a, op_b, op_lo} = '0;
  // call just after a rising edge; returns at the taking edge
  task automatic issue(input logic [3:0] o, input logic [35:0] a, b, lo);
    start <= 1'b1;
    op <= o;
    op_a <= a;
    op_b <= b;
    op_lo <= lo;
    @(posedge clk);
    start <= 1'b0;
    // stale operands flip so a late sample cannot pass
    op_a <= ~a;
    op_b <= ~b;
    op_lo <= ~lo;
  endtask
endmodule // w36_seq_model
